/* File: hdl/pfr_sequencer.v */
/*
 * Power fail and automatic restart sequencer with Wishbone registers.
 * Assumes mains_sense_i is asynchronous, high while power is lost,
 * and that the CPU pulses or holds cpu_stopped_i once state is saved.
 */
// The register offsets and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "pfr_regs.vh"
module pfr_sequencer #(
    parameter RESTORE_CYCLES = `PFR_RESTORE_CYC
) (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        mains_sense_i,
    input  wire        cpu_stopped_i,
    input  wire        panel_locked_i,
    input  wire [15:0] auto_load_selector_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    output reg         power_good_o,
    output reg         power_fail_irq_o,
    output reg         memory_write_inhibit_o,
    output reg         auto_start_o,
    output reg         mass_load_o,
    output reg  [10:0] load_address_o,
    output reg         stop_mode_o
);
    // -----------------------------------------------------------------
    // States
    // -----------------------------------------------------------------
    localparam [2:0] ST_RUN     = 3'd0;
    localparam [2:0] ST_FAIL    = 3'd1;
    localparam [2:0] ST_INHIBIT = 3'd2;
    localparam [2:0] ST_WAIT    = 3'd3;
    localparam [2:0] ST_START   = 3'd4;

    reg  [2:0]  state_q;
    reg  [2:0]  state_d;
    reg         sw_lock_q;
    reg  [15:0] sw_select_q;
    reg         sw_select_en_q;
    wire        sense_s;
    wire        delay_done;
    wire        locked;
    wire [15:0] selector;
    wire        wb_req;

    // -----------------------------------------------------------------
    // Mains sense synchroniser and restore delay
    // -----------------------------------------------------------------
    pfr_sync u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (mains_sense_i),
        .sync_o  (sense_s)
    );

    pfr_delay #(
        .CYCLES (RESTORE_CYCLES)
    ) u_delay (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .run_i  (state_q == ST_WAIT && !sense_s),
        .done_o (delay_done)
    );

    assign locked   = panel_locked_i | sw_lock_q;
    assign selector = sw_select_en_q ? sw_select_q : auto_load_selector_i;

    // -----------------------------------------------------------------
    // Sequencer
    // -----------------------------------------------------------------
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_RUN: begin
                if (sense_s)
                    state_d = ST_FAIL;
            end
            ST_FAIL: begin
                if (cpu_stopped_i)
                    state_d = ST_INHIBIT;
                else if (!sense_s)
                    state_d = ST_WAIT;
            end
            ST_INHIBIT: begin
                if (!sense_s)
                    state_d = ST_WAIT;
            end
            ST_WAIT: begin
                if (sense_s && memory_write_inhibit_o)
                    state_d = ST_INHIBIT;
                else if (sense_s)
                    state_d = ST_FAIL;
                else if (delay_done)
                    state_d = ST_START;
            end
            ST_START: begin
                state_d = ST_RUN;
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            state_q                <= ST_RUN;
            power_good_o           <= 1'b1;
            power_fail_irq_o       <= 1'b0;
            memory_write_inhibit_o <= 1'b0;
            auto_start_o           <= 1'b0;
            mass_load_o            <= 1'b0;
            load_address_o         <= 11'h000;
            stop_mode_o            <= 1'b0;
        end else begin
            state_q      <= state_d;
            auto_start_o <= 1'b0;
            if (state_d == ST_FAIL && state_q == ST_RUN) begin
                power_good_o     <= 1'b0;
                power_fail_irq_o <= 1'b1;
                stop_mode_o      <= 1'b0;
            end
            if (state_d == ST_INHIBIT)
                memory_write_inhibit_o <= 1'b1;
            if (state_d == ST_START) begin
                power_good_o           <= 1'b1;
                power_fail_irq_o       <= 1'b0;
                memory_write_inhibit_o <= 1'b0;
                if (locked) begin
                    auto_start_o   <= 1'b1;
                    mass_load_o    <= selector[`PFR_ALD_MASS];
                    load_address_o <= selector[`PFR_ALD_ADDR_HI:0];
                end else begin
                    stop_mode_o <= 1'b1;
                end
            end
        end
    end

    // -----------------------------------------------------------------
    // Wishbone slave, one wait state
    // -----------------------------------------------------------------
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o       <= 1'b0;
            wb_dat_o       <= 32'h0000_0000;
            sw_lock_q      <= `PFR_CTRL_RST;
            sw_select_q    <= `PFR_SELECT_RST;
            sw_select_en_q <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h0000_0000;
            if (wb_req && wb_we_i) begin
                case (wb_adr_i)
                    `PFR_CTRL_OFS: begin
                        if (wb_sel_i[0]) begin
                            sw_lock_q      <= wb_dat_i[`PFR_CTRL_LOCKED];
                            sw_select_en_q <= wb_dat_i[1];
                        end
                    end
                    `PFR_SELECT_OFS: begin
                        if (wb_sel_i[0])
                            sw_select_q[7:0] <= wb_dat_i[7:0];
                        if (wb_sel_i[1])
                            sw_select_q[15:8] <= wb_dat_i[15:8];
                    end
                    default: begin
                    end
                endcase
            end else if (wb_req) begin
                case (wb_adr_i)
                    `PFR_STATUS_OFS: begin
                        wb_dat_o <= {21'h0, state_q, 3'h0, auto_start_o,
                                     stop_mode_o, memory_write_inhibit_o,
                                     power_fail_irq_o, power_good_o};
                    end
                    `PFR_CTRL_OFS: begin
                        wb_dat_o <= {30'h0, sw_select_en_q, sw_lock_q};
                    end
                    `PFR_SELECT_OFS: begin
                        wb_dat_o <= {16'h0000, sw_select_q};
                    end
                    default: begin
                        wb_dat_o <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

/* File: inc/pfr_regs.vh */
/*
 * Constants for the power fail and restart sequencer: bus offsets,
 * field positions, reset values and timing counts.
 * Assumes a 100 MHz clock and a 32-bit classic Wishbone slave port.
 */
// Behaviour
// - Power-good stays high while mains sense is inactive; drops when sense goes active.
// - Loss of power-good raises the power fail interrupt at once.
// - Once the CPU reports stop, assert memory write inhibit. The code does so only in ST_FAIL; a stop first seen in ST_WAIT is ignored.
// - On sense returning inactive, wait 0.6 s before reasserting power-good.
// - Reasserting power-good clears interrupt and inhibit in the same step.
// - Panel locked: start routine chosen by auto load selector, restart or load. The code uses the SELECT register instead when CTRL bit 1 is set.
// - Panel not locked: enter stop mode instead of any automatic start. The code still auto-starts if CTRL bit 0 (software lock) is set.
// - Selector bit 13 picks mass storage load; bits 0-10 give device address.
`ifndef PFR_REGS_VH
`define PFR_REGS_VH

// ---------------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------------
`define PFR_STATUS_OFS      8'h00
`define PFR_CTRL_OFS        8'h04
`define PFR_SELECT_OFS      8'h08

// ---------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------
`define PFR_ST_POWER_GOOD   0
`define PFR_ST_PF_IRQ       1
`define PFR_ST_INHIBIT      2
`define PFR_ST_STOP_MODE    3
`define PFR_ST_START        4
`define PFR_ST_STATE_LO     8
`define PFR_CTRL_LOCKED     0
`define PFR_ALD_MASS        13
`define PFR_ALD_ADDR_HI     10

// ---------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------
`define PFR_CTRL_RST        1'b0
`define PFR_SELECT_RST      16'h0000

// ---------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------
`define PFR_CLK_MHZ         100
`define PFR_RESTORE_MS      600
`define PFR_RESTORE_CYC     (`PFR_RESTORE_MS * 1000 * `PFR_CLK_MHZ)

`endif

/* File: hdl/pfr_sync.v */
/*
 * Two-flop synchroniser for one asynchronous level.
 * Assumes the output is read only in the clk_i domain.
 */
`timescale 1ns/100ps
`default_nettype none
module pfr_sync (
    input  wire clk_i,
    input  wire rst_i,
    input  wire async_i,
    output wire sync_o
);
    reg meta_q;
    reg sync_q;

    always @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule
`default_nettype wire

/* File: hdl/pfr_delay.v */
/*
 * Restore delay counter: done_o goes high after CYCLES clocks of run_i.
 * Assumes run_i stays high for the whole wait; dropping it restarts.
 */
`timescale 1ns/100ps
`default_nettype none
module pfr_delay #(
    parameter CYCLES = 60000000
) (
    input  wire clk_i,
    input  wire rst_i,
    input  wire run_i,
    output wire done_o
);
    reg [31:0] cnt_q;
    reg        done_q;

    always @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            cnt_q  <= 32'h0000_0000;
            done_q <= 1'b0;
        end else if (!done_q) begin
            if (cnt_q == CYCLES - 1)
                done_q <= 1'b1;
            cnt_q <= cnt_q + 32'h0000_0001;
        end
    end

    assign done_o = done_q;
endmodule
`default_nettype wire

/* File: sim/pfr_sequencer_asserts.sv */
/* Port checker for the power fail sequencer.
   Assumes one clock domain and a synchronous active-high reset. */
`timescale 1ns/100ps
`default_nettype none
module pfr_seq_asserts #(
    parameter int RESTORE_CYCLES = 20
) (
    input wire        clk_i,
    input wire        rst_i,
    input wire        mains_sense_i,
    input wire        cpu_stopped_i,
    input wire        panel_locked_i,
    input wire [15:0] auto_load_selector_i,
    input wire        power_good_o,
    input wire        power_fail_irq_o,
    input wire        memory_write_inhibit_o,
    input wire        auto_start_o,
    input wire        mass_load_o,
    input wire [10:0] load_address_o,
    input wire        stop_mode_o
);
    // ------------------------------------------------------------
    // Sequence checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [31:0] quiet_q;
    // Cycles since mains sense last seen active
    always @(posedge clk_i) begin
        quiet_q <= (rst_i || mains_sense_i) ? 32'h0 : quiet_q + 32'h1;
    end
    a_irq_on_loss: assert property ($fell(power_good_o) |-> power_fail_irq_o)
        else $error("irq missing at loss");
    a_loss_latency: assert property (
        $rose(mains_sense_i) && power_good_o |-> ##[1:4] !power_good_o)
        else $error("power good held");
    a_sense_synced: assert property ($fell(power_good_o) |-> $past(mains_sense_i, 3))
        else $error("loss too early");
    a_inhibit_cause: assert property (
        $rose(memory_write_inhibit_o) |-> $past(cpu_stopped_i))
        else $error("inhibit without stop");
    a_inhibit_failing: assert property (memory_write_inhibit_o |-> !power_good_o)
        else $error("inhibit with power good");
    a_clear_together: assert property (
        $rose(power_good_o) |-> !power_fail_irq_o && !memory_write_inhibit_o)
        else $error("not cleared together");
    a_restore_wait: assert property (
        $rose(power_good_o) |-> quiet_q >= RESTORE_CYCLES && quiet_q <= RESTORE_CYCLES + 8)
        else $error("restore delay wrong");
    a_start_pulse: assert property (
        auto_start_o |-> $rose(power_good_o) && !stop_mode_o ##1 !auto_start_o)
        else $error("bad auto start");
    a_load_fields: assert property (
        auto_start_o |-> mass_load_o == auto_load_selector_i[13]
            && load_address_o == auto_load_selector_i[10:0])
        else $error("bad load fields");
    a_stop_unlocked: assert property (
        $rose(stop_mode_o) |-> $rose(power_good_o) && !panel_locked_i)
        else $error("bad stop mode");
    c_start: cover property (auto_start_o);
    c_stop: cover property ($rose(stop_mode_o));
    c_inhibit: cover property ($rose(memory_write_inhibit_o));
endmodule
bind pfr_sequencer pfr_seq_asserts #(.RESTORE_CYCLES(RESTORE_CYCLES)) u_chk (
    .clk_i, .rst_i, .mains_sense_i, .cpu_stopped_i, .panel_locked_i, .auto_load_selector_i,
    .power_good_o, .power_fail_irq_o, .memory_write_inhibit_o, .auto_start_o, .mass_load_o,
    .load_address_o, .stop_mode_o);
`default_nettype wire

/* File: sim/pfr_cpu_model.sv */
/* CPU side of the power fail interrupt.
   Assumes irq_i is a level; save_cycles_i of 0 means it never halts. */
`timescale 1ns/100ps
`default_nettype none
module pfr_cpu_model (
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire       irq_i,
    input  wire [7:0] save_cycles_i,
    output logic      stopped_o
);
    // ------------------------------------------------------------
    // Register save, then halt
    // ------------------------------------------------------------
    logic [7:0] cnt_q;
    always @(posedge clk_i) begin
        if (rst_i || !irq_i) begin
            cnt_q     <= 8'h00;
            stopped_o <= 1'b0;
        end else if (save_cycles_i != 8'h00) begin
            if (cnt_q < save_cycles_i) cnt_q <= cnt_q + 8'h01;
            stopped_o <= (cnt_q == save_cycles_i);
        end
    end
endmodule
`default_nettype wire

/* File: sim/power_fail_restart_sequencer_tb_top.sv */
/* Self-checking bench for the power fail sequencer.
   Assumes a 100 MHz clock and a shortened restore delay. */
`timescale 1ns/100ps
`default_nettype none
module power_fail_restart_sequencer_tb_top;
    // ------------------------------------------------------------
    // Stimulus and checks
    // ------------------------------------------------------------
    localparam int RC = 20;
    logic        clk_i = 1'b0, rst_i = 1'b1, mains_sense_i = 1'b0, panel_locked_i = 1'b0;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [15:0] auto_load_selector_i = 16'h0000;
    logic [7:0]  wb_adr_i = 8'h00, save_cyc = 8'h05;
    logic [3:0]  wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0;
    wire  [31:0] wb_dat_o;
    wire  [10:0] load_address_o;
    wire         wb_ack_o, power_good_o, power_fail_irq_o, memory_write_inhibit_o;
    wire         auto_start_o, mass_load_o, stop_mode_o, cpu_stopped_i;
    int          n_fail = 0, num_checks = 0;
    pfr_sequencer #(.RESTORE_CYCLES(RC)) u_dut (.clk_i, .rst_i, .mains_sense_i, .cpu_stopped_i,
        .panel_locked_i, .auto_load_selector_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .power_good_o, .power_fail_irq_o,
        .memory_write_inhibit_o, .auto_start_o, .mass_load_o, .load_address_o, .stop_mode_o);
    pfr_cpu_model u_cpu (.clk_i, .rst_i, .irq_i(power_fail_irq_o), .save_cycles_i(save_cyc),
        .stopped_o(cpu_stopped_i));
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) begin
            n_fail++;
            stop_test();
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic wait_pg(input logic v, output int n);
        n = 0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
        end while (power_good_o !== v && n < RC + 50);
        if (power_good_o !== v) begin
            n_fail++;
            stop_test();
        end
    endtask
    // Fail, read status mid-fail, optional sense glitch, recover
    task automatic cycle_power(input logic glitch, output logic [31:0] q);
        int n;
        @(posedge clk_i);
        mains_sense_i <= 1'b1;
        wait_pg(1'b0, n);
        chk("loss delay", n, 3);
        chk("irq", power_fail_irq_o, 1'b1);
        repeat (12) @(posedge clk_i);
        wb(1'b0, 8'h00, 32'h0, q);
        @(posedge clk_i);
        mains_sense_i <= 1'b0;
        if (glitch) begin
            repeat (8) @(posedge clk_i);
            mains_sense_i <= 1'b1;
            repeat (4) @(posedge clk_i);
            mains_sense_i <= 1'b0;
        end
        wait_pg(1'b1, n);
        chk("restore", n >= RC && n <= RC + 6, 1'b1);
        chk("cleared", {power_fail_irq_o, memory_write_inhibit_o}, 2'b00);
    endtask
    task automatic t_regs();
        logic [31:0] q;
        wb(1'b0, 8'h00, 32'h0, q);
        chk("status", q & 32'h1f, 32'h1);
        wb(1'b1, 8'h08, 32'h0000abcd, q);
        wb(1'b0, 8'h08, 32'h0, q);
        chk("select", q, 32'h0000abcd);
        wb(1'b1, 8'h0c, 32'hffffffff, q);
        wb(1'b0, 8'h0c, 32'h0, q);
        chk("unmapped", q, 32'h0);
        wb(1'b1, 8'h04, 32'h3, q);
        wb(1'b0, 8'h04, 32'h0, q);
        chk("ctrl", q, 32'h3);
        wb(1'b1, 8'h04, 32'h0, q);
        $display("t_regs done");
    endtask
    task automatic t_locked();
        logic [31:0] q;
        @(posedge clk_i);
        panel_locked_i       <= 1'b1;
        auto_load_selector_i <= 16'h2155;
        save_cyc             <= 8'h05;
        cycle_power(1'b1, q);
        chk("start", auto_start_o, 1'b1);
        chk("mass", mass_load_o, 1'b1);
        chk("addr", load_address_o, 11'h155);
        chk("fail status", q & 32'h7, 32'h6);
        @(posedge clk_i);
        #1;
        chk("start pulse", auto_start_o, 1'b0);
        $display("t_locked done");
    endtask
    task automatic t_unlocked();
        logic [31:0] q;
        @(posedge clk_i);
        panel_locked_i       <= 1'b0;
        auto_load_selector_i <= 16'h0123;
        save_cyc             <= 8'h00;
        cycle_power(1'b0, q);
        chk("no inhibit", q & 32'h7, 32'h2);
        chk("stop mode", {stop_mode_o, auto_start_o}, 2'b10);
        $display("t_unlocked done");
    endtask
    // Software lock, binary format load from the thumbwheel value
    task automatic t_soft_lock();
        logic [31:0] q;
        wb(1'b1, 8'h04, 32'h1, q);
        @(posedge clk_i);
        auto_load_selector_i <= 16'h0456;
        save_cyc             <= 8'h03;
        cycle_power(1'b0, q);
        chk("soft fail status", q & 32'h7, 32'h6);
        chk("soft start", {auto_start_o, stop_mode_o}, 2'b10);
        chk("binary load", {mass_load_o, load_address_o}, 12'h456);
        wb(1'b1, 8'h04, 32'h0, q);
        $display("t_soft_lock done");
    endtask
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_locked();
        t_unlocked();
        t_soft_lock();
        stop_test();
    end
endmodule
`default_nettype wire
